// ==== common/aux_ctrl_map.vh ====
`ifndef AUX_CTRL_MAP_VH
`define AUX_CTRL_MAP_VH
// Register index; its byte address on the AXI4-Lite slave is four times the index
`define AUXCTL_INDEX       10'h08e
`define AUXCTL_ADDR        10'h238
// Status word sits at the next index
`define AUXCTL_STAT_ADDR   10'h23c
// auxiliary_control field positions
`define AUX_BIT_SUPPRESS   0
`define AUX_BIT_EXTSEL     1
`define AUX_BIT_SIZE_LO    2
`define AUX_BIT_SIZE_HI    3
`define AUX_BIT_STRETCH    5
`define AUX_BIT_PULLUP_DIS 7
`define AUX_WRITABLE_MASK  8'haf
`define AUX_RESET_VALUE    8'h0c
// Timing counts in core clock cycles
`define ALE_DIV_X1         8'd6
`define ALE_DIV_X2         8'd3
`define STROBE_SHORT       8'd6
`define STROBE_LONG        8'd30
// Expanded RAM top addresses per size code
`define EXPANDED_INTERNAL_RAM_TOP_256       10'h0ff
`define EXPANDED_INTERNAL_RAM_TOP_512       10'h1ff
`define EXPANDED_INTERNAL_RAM_TOP_768       10'h2ff
`define EXPANDED_INTERNAL_RAM_TOP_1024      10'h3ff
`endif

// ==== dv/aux_bus_control_assertions.sv ====
`timescale 1ns/1ps
module aux_bus_control_chk (
  input logic        ref_clk_i, rst_n_i, ale_o, ale_oe_o, ale_weak_pullup_o, rd_n_o, wr_n_o,
  input logic        double_speed_mode_i, external_move_instruction_i,
  input logic        s_axi_rvalid, s_axi_rready,
  input logic [31:0] s_axi_rdata
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire x2 = double_speed_mode_i;
  // Both strobes high means no external move is in flight
  wire sb = rd_n_o && wr_n_o;
  property p_gap1; ale_o && !x2 |=> (!ale_o || x2 || !ale_oe_o)[*5]; endproperty
  a_gap1: assert property (p_gap1) else $error("latch pulse early");
  property p_per1; ale_o && !x2 ##1 (ale_oe_o && !x2 && !ale_o)[*5] |=> ale_o || x2 || !ale_oe_o; endproperty
  a_per1: assert property (p_per1) else $error("latch pulse missing");
  property p_per2; ale_o && x2 ##1 (ale_oe_o && x2 && !ale_o)[*2] |=> ale_o || !x2 || !ale_oe_o; endproperty
  a_per2: assert property (p_per2) else $error("fast latch pulse missing");
  property p_rel; !ale_oe_o |-> ale_weak_pullup_o && !ale_o; endproperty
  a_rel: assert property (p_rel) else $error("released latch pin misbehaves");
  property p_drv; ale_oe_o |-> !ale_weak_pullup_o; endproperty
  a_drv: assert property (p_drv) else $error("pull-up while driving");
  property p_frc; $rose(external_move_instruction_i) |-> ##[0:2] ale_oe_o; endproperty
  a_frc: assert property (p_frc) else $error("latch not driven for move");
  property p_len; $fell(sb) |-> (##6 sb) or (##30 sb); endproperty
  a_len: assert property (p_len) else $error("strobe length wrong");
  property p_low; $fell(sb) |=> (!sb)[*5]; endproperty
  a_low: assert property (p_low) else $error("strobe ended early");
  property p_rd; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd: assert property (p_rd) else $error("read data dropped");
endmodule // aux_bus_control_chk
bind aux_bus_control aux_bus_control_chk i_chk (.*);

// ==== dv/ext_mem_model.sv ====
`timescale 1ns/1ps
module ext_mem_model (
  input  logic ref_clk_i, rd_n_o, wr_n_o, ale_o, ale_oe_o, ale_weak_pullup_o,
  output logic ale_pin, strobe_wr,
  output int   strobe_len, strobe_cnt, ale_cnt
);
  int run = 0;
  // A released pin only reads high through the pull-up; anything else floats
  assign ale_pin = ale_oe_o ? ale_o : (ale_weak_pullup_o ? 1'h1 : 1'hz);
  initial begin
    strobe_len = 0;
    strobe_wr = 1'h0;
    strobe_cnt = 0;
    ale_cnt = 0;
  end
  always @(posedge ref_clk_i) begin
    if (ale_pin === 1'h1 && ale_oe_o === 1'h1) ale_cnt <= ale_cnt + 1;
    if (!wr_n_o) strobe_wr <= 1'h1;
    else if (!rd_n_o) strobe_wr <= 1'h0;
    if (!(rd_n_o && wr_n_o)) run <= run + 1;
    else if (run != 0) begin
      strobe_len <= run;
      strobe_cnt <= strobe_cnt + 1;
      run <= 0;
    end
  end
endmodule // ext_mem_model

// ==== dv/tb_aux_bus_control.sv ====
`timescale 1ns/1ps
`include "aux_ctrl_map.vh"
module tb_aux_bus_control;
  logic        ref_clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, double_speed_mode_i, xmove_req_i, xmove_write_i;
  logic        ale_o, ale_oe_o, ale_weak_pullup_o, rd_n_o, wr_n_o, expanded_internal_ram_sel_o;
  logic        port_pullup_en_o, ale_pin, strobe_wr;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_b;
  logic [2:0]  frc;
  logic [9:0]  xmove_addr_i;
  int          fails = 0, compares = 0, cyc = 0, strobe_len, strobe_cnt, ale_cnt, n0;
  // Register value, write flag, move address, expanded RAM hit, strobe length
  logic [24:0] rows [8] = '{{8'h02, 1'h0, 10'h000, 1'h0, 5'h06},
    {8'h22, 1'h1, 10'h000, 1'h0, 5'h1e}, {8'h80, 1'h0, 10'h0ff, 1'h1, 5'h00},
    {8'h80, 1'h0, 10'h100, 1'h0, 5'h06}, {8'h04, 1'h1, 10'h1ff, 1'h1, 5'h00},
    {8'h04, 1'h1, 10'h200, 1'h0, 5'h06}, {8'h08, 1'h0, 10'h2ff, 1'h1, 5'h00},
    {8'h0d, 1'h1, 10'h3ff, 1'h1, 5'h00}};
  aux_bus_control i_aux_bus_control (.*, .external_move_instruction_i(frc[0]),
    .code_table_move_i(frc[1]), .external_fetch_i(frc[2]));
  ext_mem_model i_ext_mem_model (.*);
  initial begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge ref_clk_i);
    wr_b = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge ref_clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    // Ready comes late on purpose, so the slave must hold its answer
    while (!s_axi_rvalid) @(posedge ref_clk_i);
    s_axi_rready <= 1'h1;
    do @(posedge ref_clk_i); while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic ale_window(input int exp);
    n0 = ale_cnt;
    repeat (30) @(posedge ref_clk_i);
    chk("ale_count", exp, ale_cnt - n0);
  endtask
  task print_verdict;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the well under one thousand cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 56'h0;
    {double_speed_mode_i, xmove_req_i, xmove_write_i, frc, xmove_addr_i} = 16'h0;
    rst_n_i = 0;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    rd(`AUXCTL_ADDR);
    chk("reset_value", `AUX_RESET_VALUE, rd_d);
    chk("pullup_reset", 1'h1, port_pullup_en_o);
    rd(`AUXCTL_STAT_ADDR);
    chk("status_reset", 32'h0000_0008, rd_d);
    for (int i = 0; i < 8; i++) begin
      wr(`AUXCTL_ADDR, {24'h0, rows[i][24:17]}, 4'h1);
      rd(`AUXCTL_ADDR);
      chk("readback", rows[i][24:17], rd_d);
      chk("pullup", !rows[i][24], port_pullup_en_o);
      n0 = strobe_cnt;
      @(posedge ref_clk_i);
      xmove_req_i <= 1'h1;
      xmove_write_i <= rows[i][16];
      xmove_addr_i <= rows[i][15:6];
      @(posedge ref_clk_i);
      xmove_req_i <= 1'h0;
      repeat (36) @(posedge ref_clk_i);
      chk("expanded_internal_ram_sel", rows[i][5], expanded_internal_ram_sel_o);
      chk("strobes", rows[i][4:0] != 0, strobe_cnt - n0);
      if (rows[i][4:0] != 0) chk("strobe_len", rows[i][4:0], strobe_len);
      if (rows[i][4:0] != 0) chk("strobe_dir", rows[i][16], strobe_wr);
    end
    wr(`AUXCTL_ADDR, 32'h80, 4'h0);
    rd(`AUXCTL_ADDR);
    chk("partial_write", 8'h0d, rd_d);
    chk("write_resp", 2'h0, wr_b);
    rd(10'h040);
    chk("unmapped", 2'h2, rd_r);
    wr(10'h040, 32'h00, 4'h1);
    chk("unmapped_write", 2'h2, wr_b);
    rd(`AUXCTL_ADDR);
    chk("unmapped_kept", 8'h0d, rd_d);
    wr(`AUXCTL_ADDR, 32'h00, 4'h1);
    // One edge for the latch drive enable to follow the new register value
    @(posedge ref_clk_i);
    ale_window(5);
    double_speed_mode_i <= 1'h1;
    repeat (6) @(posedge ref_clk_i);
    ale_window(10);
    double_speed_mode_i <= 1'h0;
    wr(`AUXCTL_ADDR, 32'h01, 4'h1);
    repeat (6) @(posedge ref_clk_i);
    ale_window(0);
    chk("ale_pin", 1'h1, ale_pin);
    for (int j = 0; j < 3; j++) begin
      frc <= 3'h1 << j;
      repeat (3) @(posedge ref_clk_i);
      ale_window(5);
      frc <= 3'h0;
      repeat (3) @(posedge ref_clk_i);
    end
    rst_n_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    rd(`AUXCTL_ADDR);
    chk("second_reset", `AUX_RESET_VALUE, rd_d);
    print_verdict;
  end
endmodule // tb_aux_bus_control

// ==== hw/aux_bus_control.v ====
// Operation
// RQ1: Strobe clear: address latch pulses every 6 clocks, or every 3 in double speed.
// RQ2: Strobe-suppress control sits at bit 0.
// RQ3: Suppress set: latch strobe only during external moves, table moves, external fetches.
// RQ4: While suppressed, latch pin is released and weakly pulled high.
// RQ5: Stretch bit picks read/write strobe length: 6 cycles clear, 30 set.
// RQ6: Bit 7 set disables port weak pull-ups, clear enables them.
// RQ7: Bit 1 clear sends external moves to expanded RAM, set to external memory.
// RQ8: Size field 00/01/10 limits expanded RAM to 256/512/768 bytes.
// RQ9: Software never writes ones to reserved bits 6 and 4.
// RQ10: Reset loads 0x0c; register written only as a whole byte.
// RQ11: Size 11 gives full 1024 bytes; higher addresses go external.
// RQ12: Control changes apply from the next bus cycle after the write.
`timescale 1ns/1ps
`include "aux_ctrl_map.vh"
module aux_bus_control (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // AXI4-Lite write address and data
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Core status
  input  wire        double_speed_mode_i,
  input  wire        external_move_instruction_i,
  input  wire        code_table_move_i,
  input  wire        external_fetch_i,
  // External data move request
  input  wire        xmove_req_i,
  input  wire        xmove_write_i,
  input  wire [9:0]  xmove_addr_i,
  // Pins and routing
  output reg         ale_o,
  output reg         ale_oe_o,
  output reg         ale_weak_pullup_o,
  output reg         rd_n_o,
  output reg         wr_n_o,
  output reg         expanded_internal_ram_sel_o,
  output reg         port_pullup_en_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXT  = 1'b1;

  reg  [7:0] auxiliary_control_r;
  reg  [7:0] ale_cnt_r;
  reg        state_r;
  reg        wr_r;
  reg        aw_got_r;
  reg        w_got_r;
  reg  [9:0] aw_addr_r;
  reg        w_ok_r;
  reg  [7:0] w_data_r;
  wire       strobe_busy;
  wire       strobe_done;
  wire       start_ext;
  wire [7:0] ale_div;

  function [9:0] expanded_internal_ram_top;
    input [1:0] code;
    begin
      case (code)
        2'b00:   expanded_internal_ram_top = `EXPANDED_INTERNAL_RAM_TOP_256;
        2'b01:   expanded_internal_ram_top = `EXPANDED_INTERNAL_RAM_TOP_512;
        2'b10:   expanded_internal_ram_top = `EXPANDED_INTERNAL_RAM_TOP_768;
        default: expanded_internal_ram_top = `EXPANDED_INTERNAL_RAM_TOP_1024;
      endcase
    end
  endfunction

  wire [1:0] size_code = {auxiliary_control_r[`AUX_BIT_SIZE_HI],
                          auxiliary_control_r[`AUX_BIT_SIZE_LO]}; // RQ8
  // Internal only when the select bit is clear and address fits the size
  wire in_expanded_internal_ram = !auxiliary_control_r[`AUX_BIT_EXTSEL] &&
                 (xmove_addr_i <= expanded_internal_ram_top(size_code)); // RQ7 RQ11 RQ8

  assign ale_div   = double_speed_mode_i ? `ALE_DIV_X2 : `ALE_DIV_X1; // RQ1
  assign start_ext = (state_r == ST_IDLE) && xmove_req_i && !in_expanded_internal_ram;

  strobe_timer u_strobe (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (start_ext),
    // The start edge already drives the strobe low, so the timer covers one cycle less
    .len_i     (auxiliary_control_r[`AUX_BIT_STRETCH] ? `STROBE_LONG - 8'h01
                                                      : `STROBE_SHORT - 8'h01), // RQ5
    .busy_o    (strobe_busy),
    .done_o    (strobe_done)
  );

  // Write path: address and data may arrive in either order
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auxiliary_control_r <= `AUX_RESET_VALUE; // RQ10
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 10'h000;
      w_data_r      <= 8'h00;
      w_ok_r        <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_ok_r   <= s_axi_wstrb[0];
      end
      if (aw_got_r && w_got_r) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ({aw_addr_r[9:2], 2'b00} == `AUXCTL_ADDR) begin
          s_axi_bresp <= 2'b00;
          // Whole byte only; reserved bits are kept zero
          if (w_ok_r)
            auxiliary_control_r <= w_data_r & `AUX_WRITABLE_MASK; // RQ10 RQ9 RQ12
        end else if ({aw_addr_r[9:2], 2'b00} == `AUXCTL_STAT_ADDR) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        if ({s_axi_araddr[9:2], 2'b00} == `AUXCTL_ADDR)
          s_axi_rdata <= {24'h00_0000, auxiliary_control_r};
        else if ({s_axi_araddr[9:2], 2'b00} == `AUXCTL_STAT_ADDR)
          s_axi_rdata <= {28'h000_0000, ale_oe_o, expanded_internal_ram_sel_o, strobe_busy, state_r};
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Latch strobe and external move sequencing
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ale_cnt_r         <= 8'h00;
      ale_o             <= 1'b0;
      ale_oe_o          <= 1'b1;
      ale_weak_pullup_o <= 1'b0;
      state_r           <= ST_IDLE;
      wr_r              <= 1'b0;
      rd_n_o            <= 1'b1;
      wr_n_o            <= 1'b1;
      expanded_internal_ram_sel_o        <= 1'b0;
      port_pullup_en_o  <= 1'b1;
    end else begin
      port_pullup_en_o <= !auxiliary_control_r[`AUX_BIT_PULLUP_DIS]; // RQ6
      if (ale_cnt_r >= ale_div - 8'h01)
        ale_cnt_r <= 8'h00;
      else
        ale_cnt_r <= ale_cnt_r + 8'h01;
      // Suppressed latch still runs for external cycles of any kind
      if (!auxiliary_control_r[`AUX_BIT_SUPPRESS] || external_move_instruction_i ||
          code_table_move_i || external_fetch_i || state_r == ST_EXT) begin // RQ2 RQ3
        ale_o             <= (ale_cnt_r == 8'h00); // RQ1
        ale_oe_o          <= 1'b1;
        ale_weak_pullup_o <= 1'b0;
      end else begin
        ale_o             <= 1'b0;
        ale_oe_o          <= 1'b0; // RQ4
        ale_weak_pullup_o <= 1'b1; // RQ4
      end
      case (state_r)
        ST_IDLE: begin
          if (xmove_req_i) begin
            expanded_internal_ram_sel_o <= in_expanded_internal_ram; // RQ7
            if (!in_expanded_internal_ram) begin
              state_r <= ST_EXT;
              wr_r    <= xmove_write_i;
            end
          end
        end
        ST_EXT: begin
          if (strobe_done)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
      rd_n_o <= !((start_ext && !xmove_write_i) || (strobe_busy && !wr_r)); // RQ5
      wr_n_o <= !((start_ext && xmove_write_i) || (strobe_busy && wr_r)); // RQ5
    end
  end
endmodule // aux_bus_control

// ==== hw/strobe_timer.v ====
`timescale 1ns/1ps
// Counts a strobe of a given length; busy stays high for exactly len cycles
module strobe_timer (
  // Clock and reset
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  // Control
  input  wire       start_i,
  input  wire [7:0] len_i,
  // Status
  output reg        busy_o,
  output reg        done_o
);
  reg [7:0] cnt_r;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o && start_i) begin
        cnt_r  <= len_i - 8'h01;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_r == 8'h00) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule // strobe_timer
